/* File: vdt_map.vh */
// Constants for the video DRAM row transfer controller.
// Assumes a 100 MHz system clock; times are in ns and turned into cycles here.
`ifndef VDT_MAP_VH
`define VDT_MAP_VH
`define VDT_CLK_MHZ 100
`define VDT_CYC(ns) ((((ns) * `VDT_CLK_MHZ) + 999) / 1000)
// Strobe phase, gate-to-serial-clock and column-strobe-to-serial-clock delays
`define VDT_T_STEP_NS 30
`define VDT_T_TSD_NS 20
`define VDT_T_CSD_NS 20
`define VDT_STEP_CYC `VDT_CYC(`VDT_T_STEP_NS)
`define VDT_TSD_CYC `VDT_CYC(`VDT_T_TSD_NS)
`define VDT_CSD_CYC `VDT_CYC(`VDT_T_CSD_NS)
// Serial shift clock: half period in system cycles (80 ns)
`define VDT_SC_HALF_CYC 8
// Register offsets
`define VDT_REG_CMD 4'h0
`define VDT_REG_ROW 4'h1
`define VDT_REG_COL 4'h2
`define VDT_REG_MASK 4'h3
`define VDT_REG_SER 4'h4
`define VDT_REG_SDATA 4'h5
`define VDT_REG_STATUS 4'h6
// Transfer type codes in CMD[1:0]; CMD[2] forces parallel data low
`define VDT_XFER_READ 2'h0
`define VDT_XFER_SREAD 2'h1
`define VDT_XFER_WRITE 2'h2
`define VDT_XFER_SWRITE 2'h3
`define VDT_CMD_PRELOAD 2
// Status bits
`define VDT_ST_BUSY 0
`define VDT_ST_DIR_OUT 1
`define VDT_ST_CONV_DONE 2
`define VDT_ST_HALF 3
`define VDT_ST_REFUSED 4
`define VDT_ST_SER_BUSY 5
`define VDT_ST_SRC_MSB 6
`define VDT_ST_SC_HOLD 7
`endif

/* File: vdt_sync.v */
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module vdt_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Data
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage1_ff;
  reg [W-1:0] stage2_ff;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= {W{1'b0}};
      stage2_ff <= {W{1'b0}};
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;
endmodule

/* File: vdt_div.v */
// Divider giving a one-cycle enable every DIV system clocks.
// Assumes DIV is at least 1.
`timescale 1ns/1ps
module vdt_div #(
  parameter DIV = 8
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Enable out
  output wire tick
);
  reg [7:0] cnt_ff;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff == DIV[7:0] - 8'h01) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign tick = (cnt_ff == DIV[7:0] - 8'h01);
endmodule

/* File: vdt_ctrl.v */
// Controller that drives a dual-port video DRAM through its strobes for
// row transfers and runs its serial port through the serial shift clock.
// Assumes software on the register port and a device on the pins; pin
// inputs are asynchronous and pass a two-flop synchroniser.
//
// Functional notes
// - Conventional transfer must precede any split
// - Gate low at row fall means transfer
// - Read: column, enables high, gate, select low
// - After write, hold shift clock until delay
// - Real-time read aligns gate rise with clocks; code instead holds the shift clock low for the whole transfer
// - Masked write: an enable low, select low
// - Preload write transfer with parallel data low
// - Consecutive writes: no clock until delay
// - Write-back row msb must match source read
// - Split read: all high, gate low
`timescale 1ns/1ps
`include "vdt_map.vh"
module vdt_ctrl #(
  parameter STEP_CYC = `VDT_STEP_CYC,
  parameter TSD_CYC = `VDT_TSD_CYC,
  parameter CSD_CYC = `VDT_CSD_CYC,
  parameter SC_HALF = `VDT_SC_HALF_CYC
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Software register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Device strobes and address
  output reg ras_n,
  output reg cas_n,
  output reg transfer_gate_n,
  output reg write_enable_low_byte_n,
  output reg write_enable_high_byte_n,
  output reg special_function_select,
  output reg [8:0] addr,
  // Parallel data pins, mask data only
  output reg [15:0] dq_out,
  output reg dq_oe,
  // Serial port
  output reg serial_shift_clock,
  input wire [15:0] serial_data_lines_in,
  output reg [15:0] serial_data_lines_out,
  output wire serial_data_lines_oe,
  input wire active_half_flag
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ROW = 5'h02;
  localparam [4:0] S_COL = 5'h04;
  localparam [4:0] S_GATE = 5'h08;
  localparam [4:0] S_END = 5'h10;

  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [7:0] step_ff;
  reg [7:0] gap_ff;
  reg [2:0] cmd_ff;
  reg cmd_pend_ff;
  reg [8:0] row_ff;
  reg [8:0] col_ff;
  reg [15:0] mask_ff;
  reg dir_out_ff;
  reg conv_done_ff;
  reg src_valid_ff;
  reg src_msb_ff;
  reg refused_ff;
  reg sc_hold_ff;
  reg ser_pend_ff;
  reg [15:0] sdata_ff;
  wire [15:0] sdq_sync;
  wire half_sync;
  wire sc_tick;
  wire step_done;
  wire is_write;
  wire is_split;
  wire bad_cmd;
  wire cmd_wr;
  wire ser_wr;
  wire st_wr;
  wire [15:0] status;

  vdt_sync #(.W(17)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({active_half_flag, serial_data_lines_in}),
    .dout({half_sync, sdq_sync})
  );

  vdt_div #(.DIV(SC_HALF)) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .tick(sc_tick)
  );

  assign cmd_wr = reg_wr && (reg_addr == `VDT_REG_CMD);
  assign ser_wr = reg_wr && (reg_addr == `VDT_REG_SER);
  assign st_wr = reg_wr && (reg_addr == `VDT_REG_STATUS);
  assign is_write = reg_wdata[1];
  assign is_split = reg_wdata[0];
  assign step_done = (step_ff == STEP_CYC[7:0] - 8'h01);
  assign bad_cmd = cmd_pend_ff || (state_ff != S_IDLE) || (is_split && !conv_done_ff) ||
                   (is_write && src_valid_ff && (row_ff[8] != src_msb_ff));

  // drive serial lines only in input mode
  assign serial_data_lines_oe = conv_done_ff && !dir_out_ff;

  assign status = {8'h00, sc_hold_ff, src_msb_ff, ser_pend_ff, refused_ff, half_sync,
                   conv_done_ff, dir_out_ff, (state_ff != S_IDLE) || cmd_pend_ff};

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        // start only with shift clock low
        if (cmd_pend_ff && !serial_shift_clock) begin
          nxt_state = S_ROW;
        end
      end
      S_ROW: begin
        if (step_done) begin
          nxt_state = S_COL;
        end
      end
      S_COL: begin
        if (step_done) begin
          nxt_state = S_GATE;
        end
      end
      S_GATE: begin
        if (step_done) begin
          nxt_state = S_END;
        end
      end
      S_END: begin
        if (step_done) begin
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Transfer sequencer and strobe pins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      step_ff <= 8'h00;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      transfer_gate_n <= 1'b1;
      write_enable_low_byte_n <= 1'b1;
      write_enable_high_byte_n <= 1'b1;
      special_function_select <= 1'b0;
      addr <= 9'h000;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      dir_out_ff <= 1'b0;
      conv_done_ff <= 1'b0;
      src_valid_ff <= 1'b0;
      src_msb_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= (nxt_state != state_ff) ? 8'h00 : step_ff + 8'h01;
      case (state_ff)
        S_IDLE: begin
          if (nxt_state == S_ROW) begin
            transfer_gate_n <= 1'b0;
            cas_n <= 1'b1;
            special_function_select <= cmd_ff[0];
            write_enable_low_byte_n <= ~cmd_ff[1];
            write_enable_high_byte_n <= ~cmd_ff[1];
            addr <= row_ff;
            dq_out <= cmd_ff[`VDT_CMD_PRELOAD] ? 16'h0000 : mask_ff;
            dq_oe <= cmd_ff[1];
          end
        end
        S_ROW: begin
          if (step_done) begin
            ras_n <= 1'b0;
          end
        end
        S_COL: begin
          if (step_ff == 8'h00) begin
            addr <= col_ff;
            dq_oe <= 1'b0;
          end
          if (step_done) begin
            cas_n <= 1'b0;
          end
        end
        S_GATE: begin
          if (step_done) begin
            transfer_gate_n <= 1'b1;
          end
        end
        S_END: begin
          if (step_done) begin
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            write_enable_low_byte_n <= 1'b1;
            write_enable_high_byte_n <= 1'b1;
            special_function_select <= 1'b0;
            if (!cmd_ff[0]) begin
              dir_out_ff <= ~cmd_ff[1];
              conv_done_ff <= 1'b1;
            end
            if (!cmd_ff[1]) begin
              src_valid_ff <= 1'b1;
              src_msb_ff <= row_ff[8];
            end
          end
        end
        default: begin
          ras_n <= 1'b1;
        end
      endcase
    end
  end

  // Software registers and serial clock
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= 3'h0;
      cmd_pend_ff <= 1'b0;
      row_ff <= 9'h000;
      col_ff <= 9'h000;
      mask_ff <= 16'h0000;
      refused_ff <= 1'b0;
      sc_hold_ff <= 1'b0;
      gap_ff <= 8'h00;
      ser_pend_ff <= 1'b0;
      serial_shift_clock <= 1'b0;
      serial_data_lines_out <= 16'h0000;
      sdata_ff <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `VDT_REG_CMD: reg_rdata <= {13'h0, cmd_ff};
          `VDT_REG_ROW: reg_rdata <= {7'h0, row_ff};
          `VDT_REG_COL: reg_rdata <= {7'h0, col_ff};
          `VDT_REG_MASK: reg_rdata <= mask_ff;
          `VDT_REG_SER: reg_rdata <= serial_data_lines_out;
          `VDT_REG_SDATA: reg_rdata <= sdata_ff;
          `VDT_REG_STATUS: reg_rdata <= status;
          default: reg_rdata <= 16'h0000;
        endcase
      end
      if (reg_wr && (reg_addr == `VDT_REG_ROW) && !cmd_pend_ff && (state_ff == S_IDLE)) begin
        row_ff <= reg_wdata[8:0];
      end
      if (reg_wr && (reg_addr == `VDT_REG_COL) && !cmd_pend_ff && (state_ff == S_IDLE)) begin
        col_ff <= reg_wdata[8:0];
      end
      if (reg_wr && (reg_addr == `VDT_REG_MASK) && !cmd_pend_ff && (state_ff == S_IDLE)) begin
        mask_ff <= reg_wdata;
      end
      if (cmd_wr && !bad_cmd) begin
        cmd_ff <= reg_wdata[2:0];
        cmd_pend_ff <= 1'b1;
      end else if (state_ff == S_ROW) begin
        cmd_pend_ff <= 1'b0;
      end
      // Refusal is sticky; a new refusal beats a clear in the same cycle
      if ((cmd_wr && bad_cmd) || (ser_wr && (ser_pend_ff || sc_hold_ff))) begin
        refused_ff <= 1'b1;
      end else if (st_wr && reg_wdata[`VDT_ST_REFUSED]) begin
        refused_ff <= 1'b0;
      end
      if (cmd_wr && !bad_cmd) begin
        sc_hold_ff <= 1'b1;
      end else if (state_ff == S_COL && step_done && cmd_ff[1]) begin
        gap_ff <= CSD_CYC[7:0];
      end else if (state_ff == S_GATE && step_done && !cmd_ff[1]) begin
        gap_ff <= TSD_CYC[7:0];
      end else if (gap_ff != 8'h00) begin
        gap_ff <= gap_ff - 8'h01;
      end else if (state_ff == S_IDLE && !cmd_pend_ff) begin
        sc_hold_ff <= 1'b0;
      end
      if (ser_wr && !ser_pend_ff && !sc_hold_ff) begin
        ser_pend_ff <= 1'b1;
        serial_data_lines_out <= reg_wdata;
      end else if (sc_tick && serial_shift_clock) begin
        serial_shift_clock <= 1'b0;
        ser_pend_ff <= 1'b0;
        // Half period exceeds access time, so data is settled here
        sdata_ff <= sdq_sync;
      end else if (sc_tick && ser_pend_ff && !sc_hold_ff && !cmd_pend_ff) begin
        serial_shift_clock <= 1'b1;
      end
    end
  end
endmodule

/* File: vdt_ctrl_properties.sv */
// Checker for the row transfer pin sequence of the controller.
// Assumes default timing parameters: three-cycle strobe phases, two-cycle clock holds.
`timescale 1ns/1ps
module vdt_ctrl_chk (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Device pins
  input logic ras_n,
  input logic cas_n,
  input logic transfer_gate_n,
  input logic write_enable_low_byte_n,
  input logic special_function_select,
  input logic dq_oe,
  input logic serial_shift_clock,
  input logic serial_data_lines_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_gate_at_rowfall: assert property ($fell(ras_n) |-> !transfer_gate_n && cas_n)
    else $error("row fall without transfer code");
  chk_mask_at_rowfall: assert property ($fell(ras_n) && !write_enable_low_byte_n |-> dq_oe)
    else $error("mask data not driven at row fall");
  chk_tap_then_gate: assert property ($fell(cas_n) |-> !ras_n && !transfer_gate_n
    ##[1:6] $rose(transfer_gate_n))
    else $error("column fall outside transfer or gate late");
  chk_read_dir: assert property ($rose(ras_n) && !$past(special_function_select)
    && $past(write_enable_low_byte_n) |-> !serial_data_lines_oe)
    else $error("read transfer left port driven");
  chk_write_dir: assert property ($rose(ras_n) && !$past(special_function_select)
    && !$past(write_enable_low_byte_n) |-> serial_data_lines_oe)
    else $error("write transfer left port undriven");
  chk_split_dir: assert property ($rose(ras_n) && $past(special_function_select)
    |-> $stable(serial_data_lines_oe))
    else $error("split transfer changed direction");
  chk_clock_in_row: assert property (!ras_n |-> !$rose(serial_shift_clock))
    else $error("serial clock rose in row cycle");
  chk_clock_after_gate: assert property ($rose(transfer_gate_n) |-> !$rose(serial_shift_clock) [*2])
    else $error("serial clock rose too soon after gate");
endmodule
bind vdt_ctrl vdt_ctrl_chk u_chk (.*);

/* File: vdt_dev_model.sv */
// Behavioural model of the dual-port memory's transfer and serial port.
// Assumes strobes from the controller; no array contents beyond a row pattern.
`timescale 1ns/1ps
module vdt_dev_model (
  // Strobes and address
  input logic ras_n,
  input logic cas_n,
  input logic transfer_gate_n,
  input logic write_enable_low_byte_n,
  input logic write_enable_high_byte_n,
  input logic special_function_select,
  input logic [8:0] addr,
  input logic [15:0] dq_out,
  input logic dq_oe,
  // Serial port
  input logic serial_shift_clock,
  input logic [15:0] serial_data_lines_in,
  output logic [15:0] dev_data = 16'h0000,
  output logic active_half_flag
);
  logic [15:0] serial_access_buffer [0:511];
  logic [15:0] mask_seen = 16'h0000;
  logic [8:0] row = 9'h000;
  logic [8:0] ptr = 9'h000;
  logic [1:0] kind = 2'h0;
  logic xfer = 1'b0;
  logic dir_out = 1'b0;
  assign active_half_flag = ptr[8];
  always @(negedge ras_n) begin
    xfer = !transfer_gate_n && cas_n;
    kind = {~(write_enable_low_byte_n & write_enable_high_byte_n), special_function_select};
    row = addr;
    mask_seen = dq_oe ? dq_out : 16'hFFFF;
  end
  always @(negedge cas_n) if (!ras_n && xfer) ptr = addr;
  always @(posedge transfer_gate_n) begin
    if (xfer && !kind[1])
      for (int i = 0; i < 512; i++)
        if (!kind[0] || i[8] != ptr[8]) serial_access_buffer[i] = {row[7:0], i[7:0]};
    if (xfer && !kind[0]) dir_out = !kind[1];
    // Released lines show the inverse so a stale value never matches
    if (xfer && !kind[0] && !dir_out) dev_data = ~dev_data;
    xfer = 1'b0;
  end
  always @(posedge serial_shift_clock) begin
    if (dir_out) dev_data = serial_access_buffer[ptr];
    else serial_access_buffer[ptr] = serial_data_lines_in;
    ptr = ptr + 9'h001;
  end
endmodule

/* File: vdt_ctrl_tb.sv */
// Self-checking bench for the row transfer controller.
// Assumes the device model on the pins and default timing parameters.
`timescale 1ns/1ps
module vdt_ctrl_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, rd_val, dq_out, serial_data_lines_out, serial_data_lines_in, dev_data;
  logic ras_n, cas_n, transfer_gate_n, write_enable_low_byte_n, write_enable_high_byte_n;
  logic special_function_select, dq_oe, serial_shift_clock, serial_data_lines_oe, active_half_flag;
  logic [8:0] addr;
  int err_count = 0;
  int check_count = 0;
  always #5 clock = ~clock;
  assign serial_data_lines_in = serial_data_lines_oe ? serial_data_lines_out : dev_data;
  vdt_ctrl dut (.*);
  vdt_dev_model dev (.*);
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Busy, serial pending and clock hold all clear, bounded
  task idle;
    int i;
    i = 0;
    rd(4'h6);
    while ((rd_val & 16'h00A1) !== 16'h0000 && i < 300) begin
      rd(4'h6);
      i++;
    end
    if (i == 300) begin
      err_count++;
      complete_run;
    end
  endtask
  task xfer(input logic [15:0] c, input logic [15:0] r, input logic [15:0] col, input logic dir);
    wr(4'h1, r);
    wr(4'h2, col);
    wr(4'h0, c);
    idle;
    chk({14'h0, dev.kind}, {14'h0, c[1:0]});
    chk({7'h0, dev.row}, r);
    chk({7'h0, dev.ptr}, col);
    chk({15'h0, rd_val[1]}, {15'h0, dir});
  endtask
  task t_reset;
    chk({8'h0, ras_n, cas_n, transfer_gate_n, write_enable_low_byte_n, write_enable_high_byte_n,
      special_function_select, serial_shift_clock, dq_oe}, 16'h00F8);
    rd(4'h6);
    chk(rd_val, 16'h0000);
    rd(4'hF);
    chk(rd_val, 16'h0000);
    $display("test reset done");
  endtask
  task t_split_first;
    wr(4'h0, 16'h0001);
    rd(4'h6);
    chk({15'h0, rd_val[4]}, 16'h0001);
    wr(4'h6, 16'h0010);
    rd(4'h6);
    chk({15'h0, rd_val[4]}, 16'h0000);
    $display("test split refusal done");
  endtask
  task t_read;
    xfer(16'h0000, 16'h0005, 16'h0010, 1'b1);
    wr(4'h4, 16'h0000);
    idle;
    rd(4'h5);
    chk(rd_val, 16'h0510);
    $display("test read transfer done");
  endtask
  task t_msb;
    wr(4'h1, 16'h0105);
    wr(4'h0, 16'h0002);
    rd(4'h6);
    chk({15'h0, rd_val[4]}, 16'h0001);
    wr(4'h6, 16'h0010);
    $display("test row half refusal done");
  endtask
  task t_write;
    wr(4'h3, 16'hA5A5);
    xfer(16'h0002, 16'h0007, 16'h0020, 1'b0);
    chk(dev.mask_seen, 16'hA5A5);
    wr(4'h4, 16'h1234);
    idle;
    chk(dev.serial_access_buffer[32], 16'h1234);
    xfer(16'h0006, 16'h0007, 16'h0020, 1'b0);
    chk(dev.mask_seen, 16'h0000);
    $display("test write transfer done");
  endtask
  task t_split;
    xfer(16'h0003, 16'h0007, 16'h0040, 1'b0);
    chk({15'h0, rd_val[3]}, 16'h0000);
    xfer(16'h0001, 16'h0003, 16'h0140, 1'b0);
    chk({15'h0, rd_val[3]}, 16'h0001);
    $display("test split transfers done");
  endtask
  // Second command, serial write and row write all land while busy
  task t_busy;
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0000);
    rd(4'h6);
    chk({15'h0, rd_val[4]}, 16'h0001);
    wr(4'h6, 16'h0010);
    wr(4'h4, 16'h1111);
    wr(4'h1, 16'h01FF);
    rd(4'h6);
    chk({15'h0, rd_val[4]}, 16'h0001);
    idle;
    chk({15'h0, rd_val[1]}, 16'h0001);
    rd(4'h1);
    chk(rd_val, 16'h0003);
    wr(4'h6, 16'h0010);
    $display("test busy refusal done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset;
    t_split_first;
    t_read;
    t_msb;
    t_write;
    t_split;
    t_busy;
    complete_run;
  end
endmodule
